// [logic/msc_standby_ctrl.sv]
// APB-reached module standby control with per-module clock gates.
// Overview of operation
// - Bit 5 of control register one low puts the serial unit in standby.
// - Serial unit standby holds every serial register in reset.
// - Bit 4 of control register one low puts the converter in standby.
// - Bit 2 of control register one low puts the second timer in standby.
// - Bit 0 of control register one low puts the first timer in standby.
// - First timer clock-source select ignores writes while timer stands by.
// - Detector bit low puts the low-voltage detector in standby.
// - Without the detector its bit behaves as a reserved bit.
// - Second pulse unit bit low puts that unit in standby.
// - Event counter bit low puts the event counter in standby.
// - First pulse unit bit low puts that unit in standby.
// - Display driver bit low puts the display driver in standby.
// - Watchdog bit low means standby only while the watchdog is stopped.
// - Clearing the watchdog bit while running stores 0, watchdog keeps counting.
// - Stopping the watchdog with its bit low enters standby without a write.
// - Reduced variant hides the second pulse unit and watchdog bits.
`default_nettype none
module msc_standby_ctrl #(
  parameter bit HAS_VOLTAGE_DETECTOR = 1'b1,
  parameter bit REDUCED_VARIANT = 1'b0
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic watchdog_running_i,
  input wire logic select_write_i,
  input wire logic select_data_i,
  output logic first_timer_clock_source_select_o,
  output logic serial_unit_reset_n_o,
  output msc_pkg::msc_standby_s standby_n_o,
  output logic [9:0] module_clock_o
);
  logic [7:0] ctrl1_reg;
  logic [7:0] ctrl1_next;
  logic [7:0] ctrl2_reg;
  logic [7:0] ctrl2_next;
  logic watchdog_standby_n_reg;
  logic watchdog_standby_n_next;
  msc_pkg::msc_apb_req_s req;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  assign req.psel = psel_i;
  assign req.penable = penable_i;
  assign req.pwrite = pwrite_i;
  assign req.paddr = paddr_i;
  assign req.pwdata = pwdata_i;

  // Bus decode: zero wait states, unmapped addresses answer with an error.
  wire access = req.psel & req.penable;
  wire hit1 = req.paddr == msc_pkg::MSC_CTRL1_OFFSET;
  wire hit2 = req.paddr == msc_pkg::MSC_CTRL2_OFFSET;
  wire write1 = access & req.pwrite & hit1;
  wire write2 = access & req.pwrite & hit2;

  // Only documented control bits take writes; reserved bits keep their 1.
  wire [7:0] mask2_voltage = HAS_VOLTAGE_DETECTOR ?
    msc_pkg::MSC_C2_VOLTAGE_MASK : 8'h00;
  wire [7:0] mask2_full = REDUCED_VARIANT ?
    8'h00 : msc_pkg::MSC_C2_FULL_MASK;
  wire [7:0] mask1 = msc_pkg::MSC_C1_WRITE_MASK;
  wire [7:0] mask2 = msc_pkg::MSC_C2_BASE_MASK | mask2_voltage | mask2_full;

  assign ctrl1_next = write1 ?
    ((ctrl1_reg & ~mask1) | (req.pwdata[7:0] & mask1)) : ctrl1_reg;
  assign ctrl2_next = write2 ?
    ((ctrl2_reg & ~mask2) | (req.pwdata[7:0] & mask2)) : ctrl2_reg;

  // A running watchdog keeps its clock even with its bit cleared; the bit
  // itself still stores 0 so the standby follows once the watchdog stops.
  assign watchdog_standby_n_next =
    ctrl2_reg[msc_pkg::MSC_C2_WATCHDOG] | watchdog_running_i;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl1_reg <= msc_pkg::MSC_CTRL_RESET;
      ctrl2_reg <= msc_pkg::MSC_CTRL_RESET;
      watchdog_standby_n_reg <= 1'b1;
    end else begin
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      watchdog_standby_n_reg <= watchdog_standby_n_next;
    end
  end

  wire [31:0] read_data = hit1 ? {24'h00_0000, ctrl1_reg} :
    hit2 ? {24'h00_0000, ctrl2_reg} : 32'h0000_0000;
  // Read data is caught in a flop in the setup cycle, so the access phase
  // drives the bus from a register; a write one cycle earlier already shows.
  wire setup = req.psel & ~req.penable;
  assign prdata_next = setup ? read_data : prdata_reg;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~(hit1 | hit2);

  assign standby_n_o.serial = ctrl1_reg[msc_pkg::MSC_C1_SERIAL];
  assign standby_n_o.converter =
    ctrl1_reg[msc_pkg::MSC_C1_CONVERTER];
  assign standby_n_o.second_timer =
    ctrl1_reg[msc_pkg::MSC_C1_SECOND_TIMER];
  assign standby_n_o.first_timer =
    ctrl1_reg[msc_pkg::MSC_C1_FIRST_TIMER];
  assign standby_n_o.voltage_detector =
    ctrl2_reg[msc_pkg::MSC_C2_VOLTAGE];
  assign standby_n_o.pulse_two = ctrl2_reg[msc_pkg::MSC_C2_PULSE_TWO];
  assign standby_n_o.event_counter =
    ctrl2_reg[msc_pkg::MSC_C2_EVENT];
  assign standby_n_o.watchdog = watchdog_standby_n_reg;
  assign standby_n_o.pulse_one = ctrl2_reg[msc_pkg::MSC_C2_PULSE_ONE];
  assign standby_n_o.display = ctrl2_reg[msc_pkg::MSC_C2_DISPLAY];

  assign serial_unit_reset_n_o =
    ctrl1_reg[msc_pkg::MSC_C1_SERIAL];

  // A gate lets the high phase already under way run out, so a module's
  // clock stops at the first low phase after its bit is cleared.
  wire [9:0] clock_enable = standby_n_o;

  for (genvar g = 0; g < msc_pkg::MSC_NUM_MODULES; g++) begin : g_gate
    msc_clock_gate u_gate (
      .clock_i(clock_i),
      .enable_i(clock_enable[g]),
      .gated_clock_o(module_clock_o[g])
    );
  end

  // Software is expected to wake the first timer before touching the select.
  msc_select_hold u_select (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .timer_standby_n_i(standby_n_o.first_timer),
    .select_write_i(select_write_i),
    .select_data_i(select_data_i),
    .first_timer_clock_source_select_o(first_timer_clock_source_select_o)
  );

  a_serial_bit_follow: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    write1 |=> standby_n_o.serial == $past(pwdata_i[5]))
    else $error("serial standby did not follow its written bit");

  a_serial_reset_hold: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    !standby_n_o.serial |-> !serial_unit_reset_n_o)
    else $error("serial unit left out of reset while in standby");

  a_converter_follow: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    write1 |=> standby_n_o.converter == $past(pwdata_i[4]))
    else $error("converter standby did not follow its written bit");

  a_timers_follow: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    write1 |=> standby_n_o.second_timer == $past(pwdata_i[2]) &&
      standby_n_o.first_timer == $past(pwdata_i[0]))
    else $error("timer standby did not follow its written bits");

  a_detector_reserved: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    !HAS_VOLTAGE_DETECTOR |-> ctrl2_reg[7])
    else $error("absent detector bit did not read as one");

  a_reduced_hidden: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    REDUCED_VARIANT |-> ctrl2_reg[4] && ctrl2_reg[2])
    else $error("hidden bits changed on the reduced variant");

  a_reserved_ones: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    ctrl1_reg[7] && ctrl1_reg[6] && ctrl1_reg[3] && ctrl1_reg[1] &&
      ctrl2_reg[6] && ctrl2_reg[5])
    else $error("reserved bit did not read as one");

  a_watchdog_running: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    watchdog_running_i |=> standby_n_o.watchdog)
    else $error("running watchdog was put in standby");

  a_watchdog_enter: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    $fell(watchdog_running_i) && !ctrl2_reg[2] |=> !standby_n_o.watchdog)
    else $error("stopped watchdog did not enter standby");

  a_unmapped_error: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    access && !hit1 && !hit2 |-> pslverr_o && prdata_o == 32'h0000_0000)
    else $error("unmapped access not refused");

  // Each remaining standby output follows the bit last written to its field; the watchdog's only while the watchdog is stopped.
  a_first_timer_follow: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    write1 |=> standby_n_o.first_timer == $past(pwdata_i[0]))
    else $error("first timer standby did not follow its bit");

  a_detector_follow: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    write2 && HAS_VOLTAGE_DETECTOR |=>
      standby_n_o.voltage_detector == $past(pwdata_i[7]))
    else $error("detector standby did not follow its bit");

  a_pulse_two_follow: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    write2 && !REDUCED_VARIANT |=>
      standby_n_o.pulse_two == $past(pwdata_i[4]))
    else $error("second pulse unit standby did not follow its bit");

  a_event_follow: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    write2 |=> standby_n_o.event_counter == $past(pwdata_i[3]))
    else $error("event counter standby did not follow its bit");

  a_pulse_one_follow: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    write2 |=> standby_n_o.pulse_one == $past(pwdata_i[1]))
    else $error("first pulse unit standby did not follow its bit");

  a_display_follow: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    write2 |=> standby_n_o.display == $past(pwdata_i[0]))
    else $error("display driver standby did not follow its bit");

  a_watchdog_stopped: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    !watchdog_running_i |=>
      standby_n_o.watchdog == $past(ctrl2_reg[msc_pkg::MSC_C2_WATCHDOG]))
    else $error("stopped watchdog standby did not follow its bit");

  a_watchdog_bit_store: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    write2 && !REDUCED_VARIANT |=>
      ctrl2_reg[msc_pkg::MSC_C2_WATCHDOG] == $past(pwdata_i[2]))
    else $error("watchdog bit did not store the written value");

  a_serial_release: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    standby_n_o.serial |-> serial_unit_reset_n_o)
    else $error("running serial unit held in reset");

  a_select_accepted: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    standby_n_o.first_timer && select_write_i |=>
      first_timer_clock_source_select_o == $past(select_data_i))
    else $error("select write lost while the timer was running");

  a_reduced_running: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    REDUCED_VARIANT |-> standby_n_o.pulse_two && standby_n_o.watchdog)
    else $error("hidden module entered standby on the reduced variant");

  a_absent_detector: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    !HAS_VOLTAGE_DETECTOR |-> standby_n_o.voltage_detector)
    else $error("absent detector entered standby");

  // Read data in the access phase is the register as it stood at setup.
  a_read_control_one: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    setup && hit1 |=> prdata_o == {24'h00_0000, $past(ctrl1_reg)})
    else $error("control one read back wrong");

  a_read_control_two: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    setup && hit2 |=> prdata_o == {24'h00_0000, $past(ctrl2_reg)})
    else $error("control two read back wrong");

  a_mapped_no_error: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    access && (hit1 || hit2) |-> !pslverr_o)
    else $error("mapped access answered with an error");

  a_error_quiet: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    !access |-> !pslverr_o)
    else $error("error raised outside an access phase");

  a_regs_held: assert property (@(posedge clock_i)
    disable iff (!resetn_i)
    !write1 && !write2 |=> $stable(ctrl1_reg) && $stable(ctrl2_reg))
    else $error("control register changed without a write");

  c_serial_standby: cover property (@(posedge clock_i)
    disable iff (!resetn_i) write1 ##1 !standby_n_o.serial);
  c_watchdog_deferred: cover property (@(posedge clock_i)
    disable iff (!resetn_i)
    watchdog_running_i && !ctrl2_reg[2] ##1 !watchdog_running_i
    ##1 !standby_n_o.watchdog);
  c_unmapped: cover property (@(posedge clock_i)
    disable iff (!resetn_i) pslverr_o);
  c_watchdog_held: cover property (@(posedge clock_i)
    disable iff (!resetn_i)
    watchdog_running_i && !ctrl2_reg[2] ##1 standby_n_o.watchdog);
endmodule : msc_standby_ctrl
`default_nettype wire

// [logic/msc_pkg.sv]
// Package with the register map, field positions and carriers of the block.
`default_nettype none
package msc_pkg;
  localparam int unsigned MSC_ADDR_W = 12;
  localparam logic [11:0] MSC_CTRL1_OFFSET = 12'h000;
  localparam logic [11:0] MSC_CTRL2_OFFSET = 12'h004;
  localparam logic [7:0] MSC_CTRL_RESET = 8'hFF;

  // Field positions in module_standby_control_1.
  localparam int unsigned MSC_C1_SERIAL = 5;
  localparam int unsigned MSC_C1_CONVERTER = 4;
  localparam int unsigned MSC_C1_SECOND_TIMER = 2;
  localparam int unsigned MSC_C1_FIRST_TIMER = 0;
  localparam logic [7:0] MSC_C1_WRITE_MASK = 8'h35;

  // Field positions in module_standby_control_2.
  localparam int unsigned MSC_C2_VOLTAGE = 7;
  localparam int unsigned MSC_C2_PULSE_TWO = 4;
  localparam int unsigned MSC_C2_EVENT = 3;
  localparam int unsigned MSC_C2_WATCHDOG = 2;
  localparam int unsigned MSC_C2_PULSE_ONE = 1;
  localparam int unsigned MSC_C2_DISPLAY = 0;
  localparam logic [7:0] MSC_C2_BASE_MASK = 8'h0B;
  localparam logic [7:0] MSC_C2_VOLTAGE_MASK = 8'h80;
  localparam logic [7:0] MSC_C2_FULL_MASK = 8'h14;

  localparam logic MSC_SELECT_RESET = 1'b0;
  localparam int unsigned MSC_NUM_MODULES = 10;

  // A field is 1 while its module runs and 0 while it is in standby.
  typedef struct packed {
    logic serial;
    logic converter;
    logic second_timer;
    logic first_timer;
    logic voltage_detector;
    logic pulse_two;
    logic event_counter;
    logic watchdog;
    logic pulse_one;
    logic display;
  } msc_standby_s;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } msc_apb_req_s;
endpackage : msc_pkg
`default_nettype wire

// [logic/msc_clock_gate.sv]
// Glitch-free clock gate for one peripheral module.
`default_nettype none
module msc_clock_gate (
  input wire logic clock_i,
  input wire logic enable_i,
  output logic gated_clock_o
);
  logic enable_latch;

  // The latch is open only while the clock is low, so a change of the
  // enable cannot clip a high phase already under way.
  always_latch begin
    if (!clock_i) begin
      enable_latch <= enable_i;
    end
  end

  assign gated_clock_o = clock_i & enable_latch;
endmodule : msc_clock_gate
`default_nettype wire

// [logic/msc_select_hold.sv]
// Clock-source select bit of the first timer with its standby write lock.
`default_nettype none
module msc_select_hold (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic timer_standby_n_i,
  input wire logic select_write_i,
  input wire logic select_data_i,
  output logic first_timer_clock_source_select_o
);
  logic select_reg;
  logic select_next;
  wire write_allowed = select_write_i & timer_standby_n_i;

  assign select_next = write_allowed ? select_data_i : select_reg;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      select_reg <= msc_pkg::MSC_SELECT_RESET;
    end else begin
      select_reg <= select_next;
    end
  end

  assign first_timer_clock_source_select_o = select_reg;

  a_select_locked: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !timer_standby_n_i |=> $stable(select_reg))
    else $error("select bit changed while the timer was in standby");

  c_select_refused: cover property (@(posedge clock_i) disable iff (!resetn_i)
    select_write_i && !timer_standby_n_i && select_data_i != select_reg);
endmodule : msc_select_hold
`default_nettype wire

// [sim/msc_standby_ctrl_tb_top.sv]
// Self-checking bench for the module standby control block over APB.
`default_nettype none
module msc_standby_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wd_running = 1'b0;
  logic sel_write = 1'b0;
  logic sel_data = 1'b0;
  logic sel_out;
  logic serial_rst_n;
  msc_pkg::msc_standby_s standby_n;
  logic [9:0] mod_clk;
  msc_pkg::msc_standby_s standby_min;
  logic [31:0] prdata_min;
  logic [31:0] rd_min;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int tests_run = 0;

  msc_standby_ctrl dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .watchdog_running_i(wd_running),
    .select_write_i(sel_write), .select_data_i(sel_data),
    .first_timer_clock_source_select_o(sel_out),
    .serial_unit_reset_n_o(serial_rst_n), .standby_n_o(standby_n),
    .module_clock_o(mod_clk)
  );

  // A reduced part without the detector shares the bus; its writes land in
  // the same cycles but only on the bits that this part implements.
  msc_standby_ctrl #(
    .HAS_VOLTAGE_DETECTOR(1'b0), .REDUCED_VARIANT(1'b1)
  ) dut_min (
    .clock_i(clock_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata_min), .pready_o(),
    .pslverr_o(), .watchdog_running_i(wd_running),
    .select_write_i(sel_write), .select_data_i(sel_data),
    .first_timer_clock_source_select_o(), .serial_unit_reset_n_o(),
    .standby_n_o(standby_min), .module_clock_o()
  );

  initial begin
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic report_and_stop;
    $display("Checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    rd_min = prdata_min;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      report_and_stop();
    end
  endtask : apb

  // Running modules see the main clock and parked ones a low level. A full
  // cycle passes first, since a gate finishes the high phase under way.
  task automatic gate_check(input logic [9:0] exp);
    @(posedge clock_i);
    repeat (6) begin
      #7;
      check("gated clocks", {22'h0, clock_i ? exp : 10'h000},
            {22'h0, mod_clk});
    end
  endtask : gate_check

  task automatic pulse_select(input logic v);
    @(posedge clock_i);
    sel_write <= 1'b1;
    sel_data <= v;
    @(posedge clock_i);
    sel_write <= 1'b0;
    #1;
  endtask : pulse_select

  initial begin
    #300000;
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    resetn_i <= 1'b1;
    check("standby reset", 32'h3FF, {22'h0, standby_n});
    apb(1'b0, msc_pkg::MSC_CTRL1_OFFSET, 32'h0);
    check("ctrl1 reset", 32'h0000_00FF, rd);
    apb(1'b0, msc_pkg::MSC_CTRL2_OFFSET, 32'h0);
    check("ctrl2 reset", 32'h0000_00FF, rd);
    apb(1'b1, msc_pkg::MSC_CTRL1_OFFSET, 32'hFFFF_FF00);
    #1;
    check("standby ctrl1", 32'h03F, {22'h0, standby_n});
    check("standby ctrl1", 32'h03F, {22'h0, standby_n});
    check("serial reset", 32'h0, {31'h0, serial_rst_n});
    gate_check(10'h03F);
    apb(1'b0, msc_pkg::MSC_CTRL1_OFFSET, 32'h0);
    check("ctrl1 read", 32'h0000_00CA, rd);
    pulse_select(1'b1);
    check("select locked", 32'h0, {31'h0, sel_out});
    apb(1'b1, msc_pkg::MSC_CTRL1_OFFSET, 32'h0000_00FF);
    pulse_select(1'b1);
    check("select written", 32'h1, {31'h0, sel_out});
    check("serial run", 32'h1, {31'h0, serial_rst_n});
    @(posedge clock_i);
    wd_running <= 1'b1;
    apb(1'b1, msc_pkg::MSC_CTRL2_OFFSET, 32'h0);
    repeat (2) @(posedge clock_i);
    #1;
    check("standby ctrl2", 32'h3C4, {22'h0, standby_n});
    check("standby ctrl2", 32'h3C4, {22'h0, standby_n});
    check("standby ctrl2", 32'h3C4, {22'h0, standby_n});
    check("min standby", 32'h3F4, {22'h0, standby_min});
    apb(1'b0, msc_pkg::MSC_CTRL2_OFFSET, 32'h0);
    check("ctrl2 read", 32'h0000_0060, rd);
    check("min ctrl2 read", 32'h0000_00F4, rd_min);
    wd_running <= 1'b0;
    repeat (3) @(posedge clock_i);
    #1;
    check("watchdog stop", 32'h3C0, {22'h0, standby_n});
    gate_check(10'h3C0);
    apb(1'b1, msc_pkg::MSC_CTRL2_OFFSET, 32'h0000_0014);
    apb(1'b0, msc_pkg::MSC_CTRL2_OFFSET, 32'h0);
    check("ctrl2 read", 32'h0000_0074, rd);
    apb(1'b1, 12'h008, 32'h0000_0000);
    check("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped read", 32'h0, rd);
    check("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, msc_pkg::MSC_CTRL1_OFFSET, 32'h0);
    check("ctrl1 kept", 32'h0000_00FF, rd);
    check("ctrl1 err", 32'h0, {31'h0, err});
    resetn_i <= 1'b0;
    @(posedge clock_i);
    #1;
    check("standby reset", 32'h3FF, {22'h0, standby_n});
    check("select reset", 32'h0, {31'h0, sel_out});
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    apb(1'b0, msc_pkg::MSC_CTRL2_OFFSET, 32'h0);
    check("ctrl2 after reset", 32'h0000_00FF, rd);
    check("min ctrl2 after reset", 32'h0000_00FF, rd_min);
    report_and_stop();
  end
endmodule : msc_standby_ctrl_tb_top
`default_nettype wire
